// ### core/acc_pkg.sv
/*
 analog comparator control package: register offsets, field positions,
 reset values and the comparator state enum.
 assumes a 32-bit ahb-lite slave with word-aligned registers.
*/
package acc_pkg;
   // register byte offsets (word aligned)
   localparam logic [7:0] ADDR_CONTROL = 8'h00;  // comparator_control
   localparam logic [7:0] ADDR_STATUS  = 8'h04;  // sticky event flags
   localparam logic [7:0] ADDR_MASK    = 8'h08;  // interrupt enables
   localparam logic [7:0] ADDR_PORT    = 8'h0C;  // shared pin setup/readback
   // comparator_control field positions
   localparam int BIT_ON   = 6;                  // comparator_on
   localparam int BIT_INV  = 5;                  // output_invert
   localparam int BIT_RES  = 4;                  // comparator_result
   localparam int BIT_HYST = 0;                  // hysteresis_on
   // writable bits of comparator_control
   localparam logic [7:0] CTRL_WMASK = 8'h61;
   // reset value: hysteresis on, everything else off
   localparam logic [7:0] CTRL_RESET = 8'h01;
   // status / mask bit positions
   localparam int EV_CHANGE = 0;                 // result changed
   localparam int EV_WAKE   = 1;                 // change seen while asleep
   localparam logic [1:0] EV_RESET = 2'h0;
   // port register field positions
   localparam int PT_DATA = 0;                   // port data latch
   localparam int PT_CTRL = 1;                   // port control (1 = input)
   localparam int PT_OSEL = 2;                   // drive result onto pin
   localparam int PT_RD   = 3;                   // pin read value (ro)
   localparam logic [2:0] PORT_RESET = 3'h2;
   // comparator state, gray along off -> settle -> warm -> run
   typedef enum logic [1:0] {
      ST_OFF    = 2'b00,  // powered down, result forced low
      ST_SETTLE = 2'b01,  // supply enable flop in flight
      ST_WARM   = 2'b11,  // synchroniser still holds unpowered samples
      ST_RUN    = 2'b10   // result follows the comparison
   } acc_state_e;
endpackage

// ### core/acc_sync.sv
/*
 two-flop synchroniser for the raw analog comparison result.
 assumes i_async is an asynchronous level; first flop feeds only the second.
*/
`timescale 1ns/1ps
module acc_sync (
   input  wire logic i_clk,    // system clock
   input  wire logic i_rst_n,  // synchronous reset, low active
   input  wire logic i_async,  // raw level
   output logic      o_sync    // synchronised level
);
   logic meta_q;  // first stage, read only by the second
   logic sync_q;  // second stage

   // two stages to settle metastability
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule // acc_sync

// ### core/acc_top.sv
/*
 analog comparator control: ahb-lite register slave, comparator enable,
 polarity, hysteresis, result bit, change interrupt, wake-up and the
 shared i/o pin logic.
 assumes one ahb-lite master, single word transfers, all inputs synchronous
 to i_clk except i_cmp_raw, which comes from the analog comparator.
*/
`timescale 1ns/1ps
// Operation
// - bit 6 switches comparator power
// - disabled comparator forces output low
// - bit 5 selects inverted output
// - read-only bit 4 holds result
// - bit 0 hysteresis, resets to one
// - bits 7, 3..1 read zero
// - every output change sets interrupt flag
// - flag and enable raise interrupt
// - change while asleep wakes device unless change flag already set
// - comparator keeps running while asleep
// - port control one reads zero while comparator on
// - port control zero reads data latch
// - result can drive shared pin
module acc_top (
   input  wire logic        i_clk,       // system clock, 25 MHz
   input  wire logic        i_rst_n,     // synchronous reset, low active
   input  wire logic        i_hsel,      // ahb slave select
   input  wire logic [7:0]  i_haddr,     // ahb address (low byte)
   input  wire logic [1:0]  i_htrans,    // ahb transfer type
   input  wire logic        i_hwrite,    // ahb write
   input  wire logic [2:0]  i_hsize,     // ahb size
   input  wire logic [31:0] i_hwdata,    // ahb write data
   input  wire logic        i_hready,    // ahb bus ready
   input  wire logic        i_cmp_raw,   // raw comparison, pos > neg
   input  wire logic        i_sleep,     // device in sleep or idle
   output logic [31:0]      o_hrdata,    // ahb read data
   output logic             o_hreadyout, // ahb slave ready
   output logic             o_hresp,     // ahb response, always okay
   output logic             o_cmp_power, // analog comparator supply enable
   output logic             o_hyst_en,   // analog hysteresis enable
   output logic             o_irq,       // level interrupt request
   output logic             o_wake,      // wake request to power control
   output logic             o_pin_o,     // shared pin drive value
   output logic             o_pin_oe     // shared pin drive enable
);
   logic [7:0]  ctrl_q;              // writable control bits
   logic        res_q;               // comparator_result bit
   logic        res_d;               // next result
   logic [1:0]  stat_q;              // sticky events
   logic [1:0]  mask_q;              // interrupt enables
   logic [2:0]  port_q;              // data, control, output select
   logic        wr_pend_q;           // write data phase pending
   logic        rd_pend_q;           // read data phase pending
   logic [7:0]  addr_q;              // latched address
   logic        cmp_sync;            // synchronised raw comparison
   logic        change;              // result toggles this cycle
   logic        sleep_q;             // registered sleep level
   logic [31:0] rdata_d;             // read mux
   logic [1:0]  ev_set;              // events this cycle
   logic [1:0]  w1c;                 // status bits cleared by write
   logic        addr_ok;             // valid address phase
   acc_pkg::acc_state_e st_q;        // comparator state

   // is the address one of our registers
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == acc_pkg::ADDR_CONTROL) || (a == acc_pkg::ADDR_STATUS) ||
                (a == acc_pkg::ADDR_MASK) || (a == acc_pkg::ADDR_PORT);
   endfunction

   // synchroniser for the asynchronous comparator output
   acc_sync u_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_async (i_cmp_raw),
      .o_sync  (cmp_sync)
   );

   assign addr_ok = i_hsel && i_hready && i_htrans[1];

   // ahb address phase capture; zero wait states
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end else begin
         wr_pend_q <= addr_ok && i_hwrite;
         rd_pend_q <= addr_ok && !i_hwrite;
         if (addr_ok) begin
            addr_q <= i_haddr;
         end
      end
   end

   // control register write; only bits 6, 5, 0 store
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_q <= acc_pkg::CTRL_RESET;
      end else if (wr_pend_q && addr_q == acc_pkg::ADDR_CONTROL) begin
         ctrl_q <= i_hwdata[7:0] & acc_pkg::CTRL_WMASK;
      end
   end

   // state machine: settle and warm cover the supply flop and both
   // synchroniser stages, so no sample taken while unpowered reaches the result
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q <= acc_pkg::ST_OFF;
      end else begin
         case (st_q)
            acc_pkg::ST_OFF: begin
               if (ctrl_q[acc_pkg::BIT_ON]) begin
                  st_q <= acc_pkg::ST_SETTLE;
               end
            end
            acc_pkg::ST_SETTLE: begin
               st_q <= ctrl_q[acc_pkg::BIT_ON] ? acc_pkg::ST_WARM : acc_pkg::ST_OFF;
            end
            acc_pkg::ST_WARM: begin
               st_q <= ctrl_q[acc_pkg::BIT_ON] ? acc_pkg::ST_RUN : acc_pkg::ST_OFF;
            end
            acc_pkg::ST_RUN: begin
               // sleep does not stop the comparator
               if (!ctrl_q[acc_pkg::BIT_ON]) begin
                  st_q <= acc_pkg::ST_OFF;
               end
            end
            default: st_q <= acc_pkg::ST_OFF;
         endcase
      end
   end

   // result: polarity applied, forced low when off
   always_comb begin
      if (!ctrl_q[acc_pkg::BIT_ON]) begin
         res_d = 1'b0;
      end else if (st_q == acc_pkg::ST_RUN) begin
         res_d = cmp_sync ^ ctrl_q[acc_pkg::BIT_INV];
      end else begin
         res_d = res_q;  // hold while settling
      end
   end

   // result flop
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         res_q <= 1'b0;
      end else begin
         res_q <= res_d;
      end
   end

   assign change = res_d != res_q;

   // sleep level registered
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sleep_q <= 1'b0;
      end else begin
         sleep_q <= i_sleep;
      end
   end

   // events and write-one-to-clear
   always_comb begin
      ev_set = 2'b00;
      ev_set[acc_pkg::EV_CHANGE] = change;
      // same registered sleep level as the wake pulse, but this flag also sets when a preset change flag blocks the pulse
      ev_set[acc_pkg::EV_WAKE]   = change && sleep_q && ctrl_q[acc_pkg::BIT_ON];
      w1c = (wr_pend_q && addr_q == acc_pkg::ADDR_STATUS) ? i_hwdata[1:0] : 2'b00;
   end

   // sticky flags; set wins over clear. a change flag left set before
   // sleep is what blocks the next wake pulse
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         stat_q <= acc_pkg::EV_RESET;
      end else begin
         stat_q <= (stat_q & ~w1c) | ev_set;
      end
   end

   // mask register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         mask_q <= acc_pkg::EV_RESET;
      end else if (wr_pend_q && addr_q == acc_pkg::ADDR_MASK) begin
         mask_q <= i_hwdata[1:0];
      end
   end

   // port register: data latch, control, output select
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         port_q <= acc_pkg::PORT_RESET;
      end else if (wr_pend_q && addr_q == acc_pkg::ADDR_PORT) begin
         port_q <= i_hwdata[2:0];
      end
   end

   // read mux; unmapped reads return zero. limitation: a read right behind
   // a write to the same register still sees the old value
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (addr_ok && !i_hwrite && reg_hit(i_haddr)) begin
         case (i_haddr)
            acc_pkg::ADDR_CONTROL: begin
               rdata_d[7:0] = ctrl_q;
               rdata_d[acc_pkg::BIT_RES] = res_d;
            end
            acc_pkg::ADDR_STATUS: rdata_d[1:0] = stat_q | ev_set;
            acc_pkg::ADDR_MASK:   rdata_d[1:0] = mask_q;
            acc_pkg::ADDR_PORT: begin
               rdata_d[2:0] = port_q;
               // pin readback while comparator owns the pin
               if (ctrl_q[acc_pkg::BIT_ON]) begin
                  rdata_d[acc_pkg::PT_RD] = port_q[acc_pkg::PT_CTRL] ? 1'b0
                                          : port_q[acc_pkg::PT_DATA];
               end else begin
                  rdata_d[acc_pkg::PT_RD] = port_q[acc_pkg::PT_DATA];
               end
            end
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // read data registered at the address phase edge
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_hrdata <= 32'h0000_0000;
      end else begin
         o_hrdata <= rdata_d;
      end
   end

   // outputs to analog, interrupt, wake and pin
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         o_cmp_power <= 1'b0;
         o_hyst_en   <= 1'b0;
         o_irq       <= 1'b0;
         o_wake      <= 1'b0;
         o_pin_o     <= 1'b0;
         o_pin_oe    <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         o_cmp_power <= ctrl_q[acc_pkg::BIT_ON];
         o_hyst_en   <= ctrl_q[acc_pkg::BIT_HYST];
         o_irq       <= |(stat_q & mask_q);
         // wake only on a fresh change; a preset flag blocks it
         o_wake      <= sleep_q && ev_set[acc_pkg::EV_CHANGE] && !stat_q[acc_pkg::EV_CHANGE]
                        && ctrl_q[acc_pkg::BIT_ON];
         o_pin_o     <= res_q;
         o_pin_oe    <= port_q[acc_pkg::PT_OSEL] && ctrl_q[acc_pkg::BIT_ON];
      end
   end

   // checks
   a_off_forces_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !ctrl_q[acc_pkg::BIT_ON] |=> !res_q)
      else $error("result not low while off");
   a_power_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(ctrl_q[acc_pkg::BIT_ON]) |=> o_cmp_power)
      else $error("power not raised");
   a_result_polar: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (st_q == acc_pkg::ST_RUN && ctrl_q[acc_pkg::BIT_ON]) |=>
      (ctrl_q[acc_pkg::BIT_ON] -> res_q == ($past(cmp_sync) ^ $past(ctrl_q[acc_pkg::BIT_INV]))))
      else $error("result polarity wrong");
   a_change_flags: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $changed(res_q) |-> stat_q[acc_pkg::EV_CHANGE])
      else $error("change flag missing");
   a_irq_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (stat_q[acc_pkg::EV_CHANGE] && mask_q[acc_pkg::EV_CHANGE]) |=> o_irq)
      else $error("irq missing");
   a_wake_blocked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (stat_q[acc_pkg::EV_CHANGE] && $past(stat_q[acc_pkg::EV_CHANGE])) |=> !o_wake)
      else $error("wake despite preset flag");
   a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (ctrl_q & 8'h9E) == 8'h00)
      else $error("reserved bits set");
   a_pin_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_pin_oe |-> o_pin_o == $past(res_q))
      else $error("pin value wrong");
   a_irq_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !(|(stat_q & mask_q)) |=> !o_irq)
      else $error("irq without unmasked flag");
   a_wake_flagged: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_wake |-> (stat_q[acc_pkg::EV_WAKE] && stat_q[acc_pkg::EV_CHANGE]))
      else $error("wake without flags");
   a_quiet_warmup: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      st_q != acc_pkg::ST_RUN |=> !res_q)
      else $error("result moved before run");
   c_wake: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_wake);
   c_irq: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_irq));
   c_inv_run: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      st_q == acc_pkg::ST_RUN && ctrl_q[acc_pkg::BIT_INV]);
   c_wake_blocked: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      sleep_q && change && stat_q[acc_pkg::EV_CHANGE]);
   c_pin_high: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_pin_oe && o_pin_o);
endmodule // acc_top

// ### dv/acc_analog_model.sv
/*
 behavioural model of the analog comparator core: two input voltages in
 millivolts, optional hysteresis band, raw result to the control block.
 assumes the control block drives supply and hysteresis enables.
*/
`timescale 1ns/1ps
module acc_analog_model #(
   parameter logic [15:0] HYST_MV = 16'h000A  // half width of hysteresis band
) (
   input  wire logic        i_clk,      // only used to time output moves
   input  wire logic        i_power,    // supply enable
   input  wire logic        i_hyst,     // hysteresis enable
   input  wire logic [15:0] i_pos_mv,   // positive_input voltage
   input  wire logic [15:0] i_neg_mv,   // negative_input voltage
   output logic             o_cmp_raw   // raw result, pos > neg
);
   logic [15:0] band;                   // active hysteresis band
   assign band = i_hyst ? HYST_MV : 16'h0000;
   initial o_cmp_raw = 1'b0;
   // moves on the falling edge, out of phase with the sampling logic
   always @(negedge i_clk) begin
      if (!i_power) begin
         // unpowered core gives garbage, never a clean low
         o_cmp_raw <= ~o_cmp_raw;
      end else if (!o_cmp_raw && (i_pos_mv > i_neg_mv + band)) begin
         o_cmp_raw <= 1'b1;
      end else if (o_cmp_raw && (i_pos_mv + band < i_neg_mv)) begin
         o_cmp_raw <= 1'b0;
      end
   end
endmodule // acc_analog_model

// ### dv/analog_comparator_control_test.sv
/*
 self-checking bench for acc_top: table of control settings, then reset,
 interrupt, wake and shared pin cases by hand.
 assumes acc_top answers with zero wait states and the analog model.
*/
`timescale 1ns/1ps
module analog_comparator_control_test;
   typedef struct packed {
      logic [15:0] pos;                 // positive_input millivolts
      logic [7:0]  wr;                  // control write value
      logic [7:0]  exp;                 // expected control read
   } acc_row_s;
   logic        i_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        i_hsel = 1'b0;
   logic [7:0]  i_haddr = 8'h00;
   logic [1:0]  i_htrans = 2'h0;
   logic        i_hwrite = 1'b0;
   logic [2:0]  i_hsize = 3'h2;
   logic [31:0] i_hwdata = 32'h0;
   logic        i_sleep = 1'b0;
   logic [15:0] pos_mv = 16'h0190;      // starts below negative input
   wire logic   i_cmp_raw;
   wire logic [31:0] o_hrdata;
   wire logic   o_hreadyout, o_hresp, o_cmp_power, o_hyst_en;
   wire logic   o_irq, o_wake, o_pin_o, o_pin_oe;
   int          err_total = 0;
   int          checked = 0;
   logic [31:0] rd;
   logic        seen;
   acc_row_s    rows [6] = '{
      '{16'h0258, 8'h40, 8'h50}, '{16'h0258, 8'h60, 8'h60}, '{16'h0190, 8'h60, 8'h70},
      '{16'h0190, 8'h41, 8'h41}, '{16'h0190, 8'hFF, 8'h71}, '{16'h0258, 8'h00, 8'h00}};
   always #20 i_clk = ~i_clk;
   acc_top uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
      .i_hready(o_hreadyout), .i_cmp_raw(i_cmp_raw), .i_sleep(i_sleep), .o_hrdata(o_hrdata),
      .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_cmp_power(o_cmp_power),
      .o_hyst_en(o_hyst_en), .o_irq(o_irq), .o_wake(o_wake), .o_pin_o(o_pin_o), .o_pin_oe(o_pin_oe));
   acc_analog_model u_model (.i_clk(i_clk), .i_power(o_cmp_power), .i_hyst(o_hyst_en),
      .i_pos_mv(pos_mv), .i_neg_mv(16'h01F4), .o_cmp_raw(i_cmp_raw));
   // verdict and end of run, shared with the watchdog
   task automatic finish_test;
      if (err_total == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask
   // one ahb-lite single transfer; entered just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_haddr <= a;
      i_hwrite <= w;
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= d;
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
      r = o_hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, rd);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, rd);
      chk(rd, e);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // looks for the one-cycle wake pulse over a short span
   task automatic wait_wake;
      seen = 1'b0;
      repeat (12) begin
         @(posedge i_clk);
         if (o_wake === 1'b1) seen = 1'b1;
      end
   endtask
   // hang guard, well beyond the roughly 180 cycles the run needs
   initial begin
      ticks(5000);
      err_total++;
      finish_test();
   end
   initial begin
      ticks(6);
      i_rst_n <= 1'b1;
      ticks(1);
      rd_chk(acc_pkg::ADDR_CONTROL, 32'h01);
      rd_chk(acc_pkg::ADDR_STATUS, 32'h0);
      rd_chk(acc_pkg::ADDR_MASK, 32'h0);
      rd_chk(acc_pkg::ADDR_PORT, 32'h2);
      rd_chk(8'h10, 32'h0);
      chk({31'h0, o_irq}, 32'h0);
      // table: enable, polarity, hysteresis, unused bits, forced low
      for (int i = 0; i < 6; i++) begin
         pos_mv <= rows[i].pos;
         wr(acc_pkg::ADDR_CONTROL, {24'h0, rows[i].wr});
         ticks(8);
         rd_chk(acc_pkg::ADDR_CONTROL, {24'h0, rows[i].exp});
         chk({o_cmp_power, o_hyst_en}, {rows[i].exp[6], rows[i].exp[0]});
      end
      // change flag, masking and clearing
      pos_mv <= 16'h0190;
      wr(acc_pkg::ADDR_CONTROL, 32'h40);
      ticks(8);
      wr(acc_pkg::ADDR_STATUS, 32'h3);
      wr(acc_pkg::ADDR_MASK, 32'h1);
      pos_mv <= 16'h0258;
      ticks(8);
      rd_chk(acc_pkg::ADDR_STATUS, 32'h1);
      chk({31'h0, o_irq}, 32'h1);
      wr(acc_pkg::ADDR_MASK, 32'h0);
      ticks(2);
      chk({31'h0, o_irq}, 32'h0);
      wr(acc_pkg::ADDR_STATUS, 32'h1);
      rd_chk(acc_pkg::ADDR_STATUS, 32'h0);
      // asleep: a change wakes, and the result keeps moving
      i_sleep <= 1'b1;
      ticks(2);
      pos_mv <= 16'h0190;
      wait_wake();
      chk({31'h0, seen}, 32'h1);
      rd_chk(acc_pkg::ADDR_STATUS, 32'h3);
      rd_chk(acc_pkg::ADDR_CONTROL, 32'h40);
      // flag left set by the previous wake blocks the next wake
      pos_mv <= 16'h0258;
      wait_wake();
      chk({31'h0, seen}, 32'h0);
      rd_chk(acc_pkg::ADDR_CONTROL, 32'h50);
      i_sleep <= 1'b0;
      // shared pin readback and drive
      wr(acc_pkg::ADDR_PORT, 32'h3);
      rd_chk(acc_pkg::ADDR_PORT, 32'h3);
      wr(acc_pkg::ADDR_PORT, 32'h1);
      rd_chk(acc_pkg::ADDR_PORT, 32'h9);
      wr(acc_pkg::ADDR_PORT, 32'h4);
      ticks(2);
      chk({o_pin_oe, o_pin_o}, 32'h3);
      wr(acc_pkg::ADDR_CONTROL, 32'h0);
      ticks(2);
      chk({o_pin_oe, o_cmp_power, o_hresp}, 32'h0);
      // reset again in mid-run: control and port registers, hysteresis, irq and wake back to reset values
      i_rst_n <= 1'b0;
      ticks(2);
      i_rst_n <= 1'b1;
      ticks(1);
      rd_chk(acc_pkg::ADDR_CONTROL, 32'h01);
      rd_chk(acc_pkg::ADDR_PORT, 32'h2);
      chk({o_hyst_en, o_irq, o_wake}, 32'h4);
      finish_test();
   end
endmodule // analog_comparator_control_test
